// ### core/iqc_ctrl.sv
// Interrupt flags, masks, external and pin-change detection, MCU control.
// Assumes the CPU acknowledges the vector shown on irq_vector_o and runs
// on the same clock; the register port answers reads one cycle later.
//
// How it works
// RQ1: External edge sets flag, vectors to one
// RQ2: Level sensing keeps external flag at zero
// RQ3: Pin change sets flag, vectors to two
// RQ4: Vector entry or written one clears flags
// RQ5: Compare match sets flag; ack or one clears
// RQ6: Enabled compare flag vectors to three
// RQ7: Timer1 overflow flag, clear, vector four
// RQ8: Timer0 overflow flag, clear, vector five
// RQ9: External pin works when driven as output
// RQ10: Low level requests continuously while low
// RQ11: Sense bits select low, change, fall, rise
// RQ12: Pins 0-4 always; pin 5 if input
// RQ13: Output pins and shared activity still count
// RQ14: Sample pins; pulses over one clock caught
// RQ15: Sleep instruction acts only with sleep enable
// RQ16: Sleep mode bits: idle, noise, down, reserved
// RQ17: Pullup off bit disables all pull-ups
// RQ18: Reserved bits read zero; reset clears all
// RQ19: Software disables external irq before sense change
// RQ20: Software sets sleep enable right before sleep
// RQ21: Taking irq clears global enable; return sets
// RQ22: Disabled flags stay pending until served
// RQ23: General mask holds ext and pin-change enables
// RQ24: Lowest vector address wins among pending
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module iqc_ctrl
  import iqc_pkg::*;
(
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic rst_i, // Async reset, active high
  input wire logic [5:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after rd_i
  input wire logic ext_pin_i, // External irq pin level, as read back
  input wire logic [PORT_WIDTH-1:0] port_pins_i, // Port pin levels
  input wire logic pin5_is_input_i, // Port pin 5 configured as input or I/O
  input wire iqc_tmr_evt_t tmr_evt_i, // Timer event pulses
  input wire iqc_cpu_ctl_t cpu_ctl_i, // CPU ack, enable and sleep strobes
  output logic irq_req_o, // Interrupt request to CPU
  output logic [2:0] irq_vector_o, // Vector address of the request
  output logic global_irq_enable_o, // Global enable state
  output logic sleep_enter_o, // One-cycle pulse: enter sleep
  output logic [1:0] sleep_mode_o, // Selected sleep mode
  output logic pullup_off_o // Disable port pull-ups
);

  // ==========================================================================
  // Register state
  logic [7:0] mcu_control_r;
  logic [7:0] general_irq_mask_r;
  logic [7:0] timer_irq_mask_r;
  logic ext_irq_flag_r, ext_irq_flag_nxt;
  logic pin_change_flag_r, pin_change_flag_nxt;
  logic cmp1_match_flag_r, cmp1_match_flag_nxt;
  logic timer1_overflow_flag_r, timer1_overflow_flag_nxt;
  logic timer0_overflow_flag_r, timer0_overflow_flag_nxt;
  logic global_irq_enable_r, global_irq_enable_nxt;
  logic irq_req_r;
  logic [2:0] irq_vector_r;
  logic [7:0] rdata_r;
  logic sleep_enter_r;

  // Decoded fields
  logic [1:0] ext_sense;
  logic ext_irq_enable, pin_change_enable;
  logic cmp1_match_irq_enable, timer1_overflow_irq_enable, timer0_overflow_irq_enable;
  assign ext_sense = {mcu_control_r[BIT_SENSE_HI], mcu_control_r[BIT_SENSE_LO]};
  assign ext_irq_enable = general_irq_mask_r[BIT_EXT_FLAG];
  assign pin_change_enable = general_irq_mask_r[BIT_PC_FLAG];
  assign cmp1_match_irq_enable = timer_irq_mask_r[BIT_CMP1];
  assign timer1_overflow_irq_enable = timer_irq_mask_r[BIT_T1_OVF];
  assign timer0_overflow_irq_enable = timer_irq_mask_r[BIT_T0_OVF];

  // Write strobe for one address
  function automatic logic wr_at(input logic [5:0] a);
    return wr_i && (addr_i == a);
  endfunction : wr_at

  // ==========================================================================
  // Pin sampling; the external pin rides along as the top bit.
  // The pin level is taken whatever the port direction, so driving the
  // pin as an output raises requests too.
  logic [PORT_WIDTH:0] smp_level, smp_change, smp_rise, smp_fall;

  iqc_pin_sampler #(
    .WIDTH(PORT_WIDTH + 1)
  ) u_sampler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i({ext_pin_i, port_pins_i}), // [RQ9] [RQ13]
    .level_o(smp_level),
    .change_o(smp_change),
    .rise_o(smp_rise),
    .fall_o(smp_fall)
  );

  // ==========================================================================
  // External request decode
  logic ext_edge_req, ext_level_req;
  always_comb begin
    ext_edge_req = 1'b0;
    case (ext_sense) // [RQ11]
      SENSE_CHANGE: ext_edge_req = smp_change[PORT_WIDTH];
      SENSE_FALL: ext_edge_req = smp_fall[PORT_WIDTH];
      SENSE_RISE: ext_edge_req = smp_rise[PORT_WIDTH];
      default: ext_edge_req = 1'b0;
    endcase
  end
  // Level request has no memory: it lasts exactly as long as the low pin
  assign ext_level_req = (ext_sense == SENSE_LOW) && !smp_level[PORT_WIDTH]; // [RQ10]

  // Pin change: low pins always, pin 5 only when it is an input
  logic [PORT_WIDTH-1:0] pc_qual;
  logic pc_req;
  always_comb begin
    pc_qual = {PORT_WIDTH{1'b1}};
    pc_qual[PIN5_IDX] = pin5_is_input_i; // [RQ12]
  end
  assign pc_req = |(smp_change[PORT_WIDTH-1:0] & pc_qual); // [RQ3] [RQ13]

  // ==========================================================================
  // Acknowledge decode: the CPU takes the vector currently shown
  logic [NUM_SRC-1:0] ack_hit;
  always_comb begin
    ack_hit = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      ack_hit[i] = cpu_ctl_i.irq_ack && (irq_vector_r == 3'(i + 1));
    end
  end

  // Write-one-to-clear of a flag bit at an address
  function automatic logic w1c(input logic [5:0] a, input int b);
    return wr_at(a) && wdata_i[b];
  endfunction : w1c

  // ==========================================================================
  // Flag next values: a new event wins over a clear in the same cycle
  always_comb begin
    ext_irq_flag_nxt = ext_edge_req
      || (ext_irq_flag_r && !ack_hit[SRC_EXT] && !w1c(ADDR_GEN_FLAGS, BIT_EXT_FLAG)); // [RQ1] [RQ4]
    if (ext_sense == SENSE_LOW) begin
      ext_irq_flag_nxt = 1'b0; // [RQ2]
    end
    pin_change_flag_nxt = pc_req
      || (pin_change_flag_r && !ack_hit[SRC_PC] && !w1c(ADDR_GEN_FLAGS, BIT_PC_FLAG)); // [RQ4]
    cmp1_match_flag_nxt = tmr_evt_i.cmp1_match
      || (cmp1_match_flag_r && !ack_hit[SRC_CMP1] && !w1c(ADDR_TIMER_FLAGS, BIT_CMP1)); // [RQ5]
    timer1_overflow_flag_nxt = tmr_evt_i.t1_ovf
      || (timer1_overflow_flag_r && !ack_hit[SRC_T1] && !w1c(ADDR_TIMER_FLAGS, BIT_T1_OVF)); // [RQ7]
    timer0_overflow_flag_nxt = tmr_evt_i.t0_ovf
      || (timer0_overflow_flag_r && !ack_hit[SRC_T0] && !w1c(ADDR_TIMER_FLAGS, BIT_T0_OVF)); // [RQ8]
  end

  // Flags simply hold while masked; masks never touch them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_irq_flag_r <= 1'b0;
      pin_change_flag_r <= 1'b0;
      cmp1_match_flag_r <= 1'b0;
      timer1_overflow_flag_r <= 1'b0;
      timer0_overflow_flag_r <= 1'b0;
    end else begin
      ext_irq_flag_r <= ext_irq_flag_nxt;
      pin_change_flag_r <= pin_change_flag_nxt; // [RQ22]
      cmp1_match_flag_r <= cmp1_match_flag_nxt;
      timer1_overflow_flag_r <= timer1_overflow_flag_nxt;
      timer0_overflow_flag_r <= timer0_overflow_flag_nxt;
    end
  end

  // ==========================================================================
  // Global enable: taking an interrupt closes it, return reopens it
  always_comb begin
    global_irq_enable_nxt = global_irq_enable_r;
    if (cpu_ctl_i.irq_ack || cpu_ctl_i.gie_clr) begin
      global_irq_enable_nxt = 1'b0; // [RQ21]
    end
    if (cpu_ctl_i.return_from_irq_instr || cpu_ctl_i.gie_set) begin
      global_irq_enable_nxt = 1'b1; // [RQ21]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      global_irq_enable_r <= 1'b0;
    end else begin
      global_irq_enable_r <= global_irq_enable_nxt;
    end
  end

  // ==========================================================================
  // Control and mask registers; reserved bits are never stored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mcu_control_r <= REG_RESET;
      general_irq_mask_r <= REG_RESET;
      timer_irq_mask_r <= REG_RESET;
    end else begin
      if (wr_at(ADDR_MCU_CONTROL)) begin
        mcu_control_r <= wdata_i & MASK_MCU_CONTROL; // [RQ18]
      end
      if (wr_at(ADDR_GEN_MASK)) begin
        general_irq_mask_r <= wdata_i & MASK_GEN; // [RQ23]
      end
      if (wr_at(ADDR_TIMER_MASK)) begin
        timer_irq_mask_r <= wdata_i & MASK_TIMER; // [RQ18]
      end
    end
  end

  // ==========================================================================
  // Arbitration on next-cycle state, so the request drops the cycle after
  // an acknowledge instead of showing a stale vector
  logic [NUM_SRC-1:0] pend;
  logic pend_any;
  logic [2:0] pend_vec;
  always_comb begin
    pend = '0;
    pend[SRC_EXT] = (ext_irq_flag_nxt || ext_level_req) && ext_irq_enable; // [RQ1] [RQ10]
    pend[SRC_PC] = pin_change_flag_nxt && pin_change_enable; // [RQ3]
    pend[SRC_CMP1] = cmp1_match_flag_nxt && cmp1_match_irq_enable; // [RQ6]
    pend[SRC_T1] = timer1_overflow_flag_nxt && timer1_overflow_irq_enable; // [RQ7]
    pend[SRC_T0] = timer0_overflow_flag_nxt && timer0_overflow_irq_enable; // [RQ8]
  end

  iqc_prio u_prio (
    .pend_i(pend),
    .any_o(pend_any),
    .vector_o(pend_vec)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_req_r <= 1'b0;
      irq_vector_r <= VEC_NONE;
    end else begin
      irq_req_r <= pend_any && global_irq_enable_nxt; // [RQ22]
      irq_vector_r <= (pend_any && global_irq_enable_nxt) ? pend_vec : VEC_NONE; // [RQ24]
    end
  end

  // ==========================================================================
  // Sleep: the instruction has no effect unless sleep enable is set
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_enter_r <= 1'b0;
    end else begin
      sleep_enter_r <= cpu_ctl_i.sleep_instr && mcu_control_r[BIT_SLEEP_EN]; // [RQ15]
    end
  end

  // ==========================================================================
  // Register read port; unmapped addresses read zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= REG_RESET;
    end else begin
      rdata_r <= REG_RESET;
      if (rd_i) begin
        case (addr_i)
          ADDR_MCU_CONTROL: rdata_r <= mcu_control_r;
          ADDR_GEN_MASK: rdata_r <= general_irq_mask_r;
          ADDR_TIMER_MASK: rdata_r <= timer_irq_mask_r;
          ADDR_GEN_FLAGS: begin
            rdata_r[BIT_EXT_FLAG] <= ext_irq_flag_r; // [RQ18]
            rdata_r[BIT_PC_FLAG] <= pin_change_flag_r;
          end
          ADDR_TIMER_FLAGS: begin
            rdata_r[BIT_CMP1] <= cmp1_match_flag_r;
            rdata_r[BIT_T1_OVF] <= timer1_overflow_flag_r;
            rdata_r[BIT_T0_OVF] <= timer0_overflow_flag_r;
          end
          default: rdata_r <= REG_RESET;
        endcase
      end
    end
  end

  // Outputs straight from flops
  assign rdata_o = rdata_r;
  assign irq_req_o = irq_req_r;
  assign irq_vector_o = irq_vector_r;
  assign global_irq_enable_o = global_irq_enable_r;
  assign sleep_enter_o = sleep_enter_r;
  assign sleep_mode_o = {mcu_control_r[BIT_SLEEP_MODE_HI], mcu_control_r[BIT_SLEEP_MODE_LO]}; // [RQ16]
  assign pullup_off_o = mcu_control_r[BIT_PULLUP_OFF]; // [RQ17]

  // ==========================================================================
  // Checks
  sequence s_ack_taken;
    cpu_ctl_i.irq_ack && !cpu_ctl_i.return_from_irq_instr && !cpu_ctl_i.gie_set;
  endsequence
  sequence s_gie_low;
    !global_irq_enable_o;
  endsequence

  property p_level_no_flag;
    @(posedge clk_i) disable iff (rst_i) (ext_sense == SENSE_LOW) |=> !ext_irq_flag_r;
  endproperty
  a_level_no_flag: assert property (p_level_no_flag) else $error("ext flag set in level mode"); // [RQ2]

  property p_ext_edge_sets;
    @(posedge clk_i) disable iff (rst_i)
      (ext_sense == SENSE_FALL && smp_fall[PORT_WIDTH]) |=> ext_irq_flag_r;
  endproperty
  a_ext_edge_sets: assert property (p_ext_edge_sets) else $error("falling edge lost"); // [RQ1]

  property p_level_req;
    @(posedge clk_i) disable iff (rst_i)
      (ext_level_req && ext_irq_enable && global_irq_enable_nxt) |=> (irq_req_o && irq_vector_o == 3'h1);
  endproperty
  a_level_req: assert property (p_level_req) else $error("low level not requested"); // [RQ10]

  property p_ack_clears_gie;
    @(posedge clk_i) disable iff (rst_i) s_ack_taken |=> s_gie_low ##0 !irq_req_o;
  endproperty
  a_ack_clears_gie: assert property (p_ack_clears_gie) else $error("ack left global enable set"); // [RQ21]

  property p_return_from_irq_instr_sets;
    @(posedge clk_i) disable iff (rst_i) cpu_ctl_i.return_from_irq_instr |=> global_irq_enable_o;
  endproperty
  a_return_from_irq_instr_sets: assert property (p_return_from_irq_instr_sets) else $error("return did not set enable"); // [RQ21]

  property p_ack_clears_cmp;
    @(posedge clk_i) disable iff (rst_i)
      (cpu_ctl_i.irq_ack && irq_vector_o == 3'h3 && !tmr_evt_i.cmp1_match) |=> !cmp1_match_flag_r;
  endproperty
  a_ack_clears_cmp: assert property (p_ack_clears_cmp) else $error("compare flag not cleared"); // [RQ5]

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
      (tmr_evt_i.t0_ovf && wr_i && addr_i == ADDR_TIMER_FLAGS && wdata_i[BIT_T0_OVF]) |=> timer0_overflow_flag_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overflow event lost to clear"); // [RQ8]

  property p_t1_vector;
    @(posedge clk_i) disable iff (rst_i)
      (global_irq_enable_o && timer1_overflow_flag_r && timer1_overflow_irq_enable && !cpu_ctl_i.irq_ack
       && !cpu_ctl_i.gie_clr && !ext_irq_enable && !pin_change_enable && !cmp1_match_flag_r
       && !tmr_evt_i.cmp1_match && !(wr_i && addr_i == ADDR_TIMER_FLAGS && wdata_i[BIT_T1_OVF]))
      |=> (irq_req_o && irq_vector_o == 3'h4);
  endproperty
  a_t1_vector: assert property (p_t1_vector) else $error("timer1 overflow not vectored"); // [RQ7]

  property p_sleep_gated;
    @(posedge clk_i) disable iff (rst_i)
      (cpu_ctl_i.sleep_instr && !mcu_control_r[BIT_SLEEP_EN]) |=> !sleep_enter_o;
  endproperty
  a_sleep_gated: assert property (p_sleep_gated) else $error("sleep without enable"); // [RQ15]

  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i)
      (rd_i && addr_i == ADDR_GEN_FLAGS) |=> ((rdata_o & ~MASK_GEN) == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read nonzero"); // [RQ18]

  property p_prio;
    @(posedge clk_i) disable iff (rst_i)
      (pend[SRC_PC] && global_irq_enable_nxt) |=> (irq_req_o && irq_vector_o <= 3'h2);
  endproperty
  a_prio: assert property (p_prio) else $error("lower priority vector won"); // [RQ24]

endmodule : iqc_ctrl

// ### core/iqc_pin_sampler.sv
// Samples pins into flops and flags changes and edges between samples.
// Assumes pin inputs are already synchronous to clk_i.
`timescale 1ns/1ps
module iqc_pin_sampler
  import iqc_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Async reset, active high
  input wire logic [WIDTH-1:0] pins_i, // Raw pin levels
  output logic [WIDTH-1:0] level_o, // Sampled level
  output logic [WIDTH-1:0] change_o, // Level differs from previous sample
  output logic [WIDTH-1:0] rise_o, // Low to high between samples
  output logic [WIDTH-1:0] fall_o // High to low between samples
);

  logic [WIDTH-1:0] cur_r;
  logic [WIDTH-1:0] prev_r;

  // ==========================================================================
  // Two sample stages; edges are judged only on sampled values
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_r <= '0;
      prev_r <= '0;
    end else begin
      cur_r <= pins_i; // [RQ14]
      prev_r <= cur_r;
    end
  end

  // Any level held across one clock edge is seen as a change
  assign level_o = cur_r;
  assign change_o = cur_r ^ prev_r; // [RQ14]
  assign rise_o = cur_r & ~prev_r;
  assign fall_o = ~cur_r & prev_r;

  property p_pulse_seen;
    @(posedge clk_i) disable iff (rst_i)
      (pins_i != cur_r) |=> (change_o != '0);
  endproperty
  a_pulse_seen: assert property (p_pulse_seen) else $error("pin change not detected"); // [RQ14]

endmodule : iqc_pin_sampler

// ### core/iqc_pkg.sv
// Constants and carrier types for the interrupt flag and control block.
// Assumes an 8-bit I/O register space reached by a 6-bit register address.
package iqc_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [5:0] ADDR_MCU_CONTROL = 6'h35;
  localparam logic [5:0] ADDR_TIMER_FLAGS = 6'h38;
  localparam logic [5:0] ADDR_TIMER_MASK = 6'h39;
  localparam logic [5:0] ADDR_GEN_FLAGS = 6'h3a;
  localparam logic [5:0] ADDR_GEN_MASK = 6'h3b;

  // ==========================================================================
  // Implemented bits of each register; all others read zero
  localparam logic [7:0] MASK_MCU_CONTROL = 8'h7b;
  localparam logic [7:0] MASK_GEN = 8'h60;
  localparam logic [7:0] MASK_TIMER = 8'h46;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int BIT_EXT_FLAG = 6;
  localparam int BIT_PC_FLAG = 5;
  localparam int BIT_CMP1 = 6;
  localparam int BIT_T1_OVF = 2;
  localparam int BIT_T0_OVF = 1;
  localparam int BIT_PULLUP_OFF = 6;
  localparam int BIT_SLEEP_EN = 5;
  localparam int BIT_SLEEP_MODE_HI = 4;
  localparam int BIT_SLEEP_MODE_LO = 3;
  localparam int BIT_SENSE_HI = 1;
  localparam int BIT_SENSE_LO = 0;

  // ==========================================================================
  // External sense and sleep mode encodings
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_CHANGE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  localparam logic [1:0] SLEEP_IDLE = 2'h0;
  localparam logic [1:0] SLEEP_NOISE_RED = 2'h1;
  localparam logic [1:0] SLEEP_POWER_DOWN = 2'h2;
  localparam logic [1:0] SLEEP_RESERVED = 2'h3;

  // ==========================================================================
  // Sources in priority order; vector address is index plus one
  localparam int NUM_SRC = 5;
  localparam int SRC_EXT = 0;
  localparam int SRC_PC = 1;
  localparam int SRC_CMP1 = 2;
  localparam int SRC_T1 = 3;
  localparam int SRC_T0 = 4;
  localparam logic [2:0] VEC_NONE = 3'h0;
  localparam int PORT_WIDTH = 6;
  localparam int PIN5_IDX = 5;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic cmp1_match;
    logic t1_ovf;
    logic t0_ovf;
  } iqc_tmr_evt_t;

  typedef struct packed {
    logic irq_ack;
    logic gie_set;
    logic gie_clr;
    logic return_from_irq_instr;
    logic sleep_instr;
  } iqc_cpu_ctl_t;

endpackage : iqc_pkg

// ### core/iqc_prio.sv
// Fixed-priority pick among pending interrupt sources.
// Assumes index zero is the highest priority source.
`timescale 1ns/1ps
module iqc_prio
  import iqc_pkg::*;
(
  input wire logic [NUM_SRC-1:0] pend_i, // Enabled pending sources
  output logic any_o, // At least one pending
  output logic [2:0] vector_o // Winning vector, zero when none
);

  // Lowest index wins, which is also the lowest vector address
  function automatic logic [2:0] pick(input logic [NUM_SRC-1:0] p);
    logic [2:0] v;
    v = VEC_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        v = 3'(i + 1);
      end
    end
    return v;
  endfunction : pick

  assign any_o = |pend_i;
  assign vector_o = pick(pend_i); // [RQ24]

endmodule : iqc_prio

// ### tb/iqc_cpu_model.sv
// CPU stand-in: takes a standing request with a one-cycle ack, returns later.
// Assumes request and vector from the block are registered on clk_i.
`timescale 1ns/1ps
module iqc_cpu_model
  import iqc_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Async reset, active high
  input wire logic req_i, // Request from the block
  input wire logic serve_i, // Take requests while high
  input wire logic [3:0] gap_i, // Handler length before return
  input wire logic gie_set_i, // Software enable strobe
  input wire logic sleep_i, // Sleep instruction strobe
  output iqc_cpu_ctl_t cpu_ctl_o // Strobes to the block
);
  logic ack_r;
  logic return_from_irq_instr_r;
  logic [3:0] cnt_r;
  // =====
  // Ack once, then no new ack until the return, as a real core would
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      return_from_irq_instr_r <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      ack_r <= serve_i && req_i && !ack_r && cnt_r == 4'h0;
      return_from_irq_instr_r <= cnt_r == 4'h1;
      if (ack_r) begin
        cnt_r <= gap_i + 4'h1;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  // Global clear is left to the block itself
  assign cpu_ctl_o = '{irq_ack: ack_r, gie_set: gie_set_i, gie_clr: 1'b0, return_from_irq_instr: return_from_irq_instr_r, sleep_instr: sleep_i};
endmodule : iqc_cpu_model

// ### tb/iqc_ctrl_bench.sv
// Self-checking bench for the interrupt flag and control block.
// Assumes the CPU stand-in drives the CPU strobes of the block.
`timescale 1ns/1ps
module iqc_ctrl_bench
  import iqc_pkg::*;
;
  logic clk_i, rst_i, wr_i, rd_i, ext_pin_i, pin5_is_input_i, serve, gie_set, sleep;
  logic irq_req_o, global_irq_enable_o, sleep_enter_o, pullup_off_o;
  logic [5:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic [PORT_WIDTH-1:0] port_pins_i;
  logic [2:0] irq_vector_o;
  logic [1:0] sleep_mode_o;
  logic [3:0] gap;
  iqc_tmr_evt_t tmr_evt_i;
  iqc_cpu_ctl_t cpu_ctl_i;
  int err_total, compares;
  iqc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .ext_pin_i(ext_pin_i), .port_pins_i(port_pins_i), .pin5_is_input_i(pin5_is_input_i),
    .tmr_evt_i(tmr_evt_i), .cpu_ctl_i(cpu_ctl_i), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
    .global_irq_enable_o(global_irq_enable_o), .sleep_enter_o(sleep_enter_o), .sleep_mode_o(sleep_mode_o),
    .pullup_off_o(pullup_off_o));
  iqc_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .req_i(irq_req_o), .serve_i(serve), .gap_i(gap),
    .gie_set_i(gie_set), .sleep_i(sleep), .cpu_ctl_o(cpu_ctl_i));
  // =====
  // Shared compare, verdict and bus cycles
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask : chk
  task automatic results();
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", e, rdata_o);
  endtask : rd
  // Bounded wait for the core to take a vector; a hang ends the run
  task automatic wait_ack(input logic [2:0] v);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_i);
      #1;
      if (cpu_ctl_i.irq_ack === 1'b1) begin
        chk("vector", {5'h00, v}, {5'h00, irq_vector_o});
        return;
      end
    end
    err_total++;
    results();
  endtask : wait_ack
  // All timer events in one cycle, optionally beside a flag clear write
  task automatic evt(input logic [7:0] c);
    @(posedge clk_i);
    tmr_evt_i <= 3'h7;
    addr_i <= ADDR_TIMER_FLAGS;
    wdata_i <= c;
    wr_i <= c != 8'h00;
    @(posedge clk_i);
    tmr_evt_i <= 3'h0;
    wr_i <= 1'b0;
  endtask : evt
  // Ext pin and port pin 0 share one activity, so the pin change flag rises and the ext flag rises when the sense matches
  task automatic pins(input logic v);
    @(posedge clk_i);
    ext_pin_i <= v;
    port_pins_i[0] <= v;
    repeat (4) @(posedge clk_i);
  endtask : pins
  task automatic slp(input logic [7:0] ctl, input logic e);
    wr(ADDR_MCU_CONTROL, ctl);
    @(posedge clk_i);
    sleep <= 1'b1;
    @(posedge clk_i);
    sleep <= 1'b0;
    #1 chk("sleep_enter", {7'h00, e}, {7'h00, sleep_enter_o});
    chk("sleep_mode", {6'h00, ctl[4:3]}, {6'h00, sleep_mode_o});
  endtask : slp
  // =====
  // Scenarios
  task automatic t_regs();
    logic [5:0] a [6] = '{6'h35, 6'h38, 6'h39, 6'h3a, 6'h3b, 6'h3c};
    logic [7:0] e [6] = '{8'h7b, 8'h00, 8'h46, 8'h00, 8'h60, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rd(a[i], 8'h00);
      wr(a[i], 8'hff);
      rd(a[i], e[i]);
    end
    chk("pullup_off", 8'h01, {7'h00, pullup_off_o});
    wr(ADDR_TIMER_MASK, 8'h00);
    wr(ADDR_GEN_MASK, 8'h00);
    slp(8'h18, 1'b0);
    chk("pullup_off", 8'h00, {7'h00, pullup_off_o});
    for (int m = 0; m < 4; m++) slp(8'h20 | 8'(m << 3), 1'b1);
  endtask : t_regs
  task automatic t_timer();
    wr(ADDR_TIMER_MASK, MASK_TIMER);
    evt(8'h00);
    rd(ADDR_TIMER_FLAGS, MASK_TIMER);
    chk("irq_req", 8'h00, {7'h00, irq_req_o});
    @(posedge clk_i);
    gap <= 4'h5;
    serve <= 1'b1;
    gie_set <= 1'b1;
    @(posedge clk_i);
    gie_set <= 1'b0;
    wait_ack(3'h3);
    wait_ack(3'h4);
    wait_ack(3'h5);
    rd(ADDR_TIMER_FLAGS, 8'h00);
    wr(ADDR_TIMER_MASK, 8'h00);
    evt(8'hc2);
    rd(ADDR_TIMER_FLAGS, MASK_TIMER);
    wr(ADDR_TIMER_FLAGS, 8'hc2);
    rd(ADDR_TIMER_FLAGS, 8'h04);
    wr(ADDR_TIMER_FLAGS, 8'h04);
    rd(ADDR_TIMER_FLAGS, 8'h00);
  endtask : t_timer
  task automatic t_ext();
    for (int s = 1; s < 4; s++) begin
      wr(ADDR_GEN_MASK, 8'h00);
      wr(ADDR_MCU_CONTROL, 8'(s));
      pins(1'b1);
      rd(ADDR_GEN_FLAGS, {1'b0, s != 2, 6'h20});
      wr(ADDR_GEN_FLAGS, 8'h60);
      pins(1'b0);
      rd(ADDR_GEN_FLAGS, {1'b0, s != 3, 6'h20});
      wr(ADDR_GEN_FLAGS, 8'h60);
    end
    wr(ADDR_MCU_CONTROL, 8'h00);
    rd(ADDR_GEN_FLAGS, 8'h00);
    wr(ADDR_GEN_MASK, 8'h40);
    wait_ack(3'h1);
    @(posedge clk_i);
    #1 chk("gie", 8'h00, {7'h00, global_irq_enable_o});
    wait_ack(3'h1);
    pins(1'b1);
    repeat (8) @(posedge clk_i);
    #1 chk("gie", 8'h01, {7'h00, global_irq_enable_o});
    chk("irq_req", 8'h00, {7'h00, irq_req_o});
    wr(ADDR_GEN_MASK, 8'h00);
  endtask : t_ext
  task automatic t_pc();
    wr(ADDR_GEN_FLAGS, 8'h60);
    for (int i = 1; i < 6; i++) begin
      @(posedge clk_i);
      port_pins_i[i] <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(ADDR_GEN_FLAGS, (i < 5) ? 8'h20 : 8'h00);
      wr(ADDR_GEN_FLAGS, 8'h60);
    end
    pin5_is_input_i <= 1'b1;
    @(posedge clk_i);
    port_pins_i[5] <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(ADDR_GEN_FLAGS, 8'h20);
    gap <= 4'h0;
    wr(ADDR_GEN_MASK, 8'h20);
    wait_ack(3'h2);
    rd(ADDR_GEN_FLAGS, 8'h00);
  endtask : t_pc
  // =====
  // Clock, reset and the main sequence
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, wr_i, rd_i, ext_pin_i, pin5_is_input_i, serve, gie_set, sleep} = 8'h80;
    {addr_i, wdata_i, port_pins_i, gap} = '0;
    tmr_evt_i = 3'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_timer();
    t_ext();
    t_pc();
    results();
  end
endmodule : iqc_ctrl_bench
